// *** inc/asp_pkg.sv ***
// Types shared by the serial channel and its bench.
package asp_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } asp_apb_req_type;

  typedef struct packed {
    logic ckPin;
    logic dtPin;
  } asp_pins_in_type;

  typedef struct packed {
    logic ckO;
    logic ckOe;
    logic dtO;
    logic dtOe;
  } asp_pins_out_type;

  typedef struct packed {
    logic [7:0] txCtl;
    logic [7:0] rxCtl;
    logic [7:0] baud;
    logic [7:0] baudCnt;
    logic [7:0] txBuf;
    logic txBufFull;
    logic txBusy;
    logic [10:0] txShift;
    logic [3:0] txBits;
    logic [6:0] txPhase;
    logic rxBusy;
    logic [8:0] rxWord;
    logic [3:0] rxIdx;
    logic [6:0] rxPhase;
    logic [1:0] votes;
    logic [7:0] rxData;
    logic rxReady;
    logic frameErr;
    logic overrun;
    logic rxNinth;
    logic [7:0] portLatch;
    logic [7:0] portDir;
    logic [2:0] ckSync;
    logic [2:0] dtSync;
    logic [31:0] rdata;
    asp_pins_out_type pins;
  } asp_state_type;
endpackage : asp_pkg

// *** inc/asp_regs.svh ***
// Register offsets, field positions, reset values and bit timing of the serial channel.
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ASP_ADDR_TXCTL 8'h00
`define ASP_ADDR_RXCTL 8'h04
`define ASP_ADDR_BAUD 8'h08
`define ASP_ADDR_TXDATA 8'h0C
`define ASP_ADDR_RXDATA 8'h10
`define ASP_ADDR_LATCH 8'h14
`define ASP_ADDR_DIR 8'h18
`define ASP_ADDR_STATUS 8'h1C
// ----------------------------------------------------------------
// Transmit control fields
// ----------------------------------------------------------------
`define ASP_TXC_CLKSRC 7
`define ASP_TXC_NINE 6
`define ASP_TXC_EN 5
`define ASP_TXC_SYNC 4
`define ASP_TXC_HIGH 2
`define ASP_TXC_NINTH 0
`define ASP_TXC_WMASK 8'hF5
// ----------------------------------------------------------------
// Receive control fields
// ----------------------------------------------------------------
`define ASP_RXC_SEN 7
`define ASP_RXC_NINE 6
`define ASP_RXC_SINGLE 5
`define ASP_RXC_CONT 4
`define ASP_RXC_ADDR 3
`define ASP_RXC_WMASK 8'hF8
// ----------------------------------------------------------------
// Port fields and reset values
// ----------------------------------------------------------------
`define ASP_LAT_OD 7
`define ASP_PIN_CK 1
`define ASP_PIN_DT 2
`define ASP_CTL_RESET 8'h00
`define ASP_DIR_RESET 8'hFF
// ----------------------------------------------------------------
// Baud ticks per bit time and last sync phase
// ----------------------------------------------------------------
`define ASP_TICKS_LOW 7'h40
`define ASP_TICKS_HIGH 7'h10
`define ASP_TICKS_SYNC 7'h04
`define ASP_SYNC_LAST 7'h03
`endif

// *** rtl/asp_core.sv ***
// Addressable serial channel: async transceiver or sync master/slave behind an APB slave.
// How it works
// R1: Three modes: async full duplex, sync master and sync slave, half duplex.
// R2: Software sets serial enable; the channel then picks pin directions per mode.
// R3: With serial enable set, the channel drives the pins it needs itself.
// R4: Open-drain select makes the clock/transmit pin only pull low.
// R5: Clock source bit picks master or slave in sync mode only.
// R6: Transmit width bit picks nine-bit frames; ninth bit from control bit 0.
// R7: Transmit enable starts sending; in sync mode receive enables win.
// R8: Mode bit picks synchronous or asynchronous operation.
// R9: High-speed bit sets async rate only; bit 3 reads zero.
// R10: Shift-empty status reads one when idle, also after reset.
// R11: Serial enable claims pins; clear holds the channel in reset.
// R12: Receive width bit picks nine-bit reception.
// R13: Single receive takes one word in sync master mode, then self-clears.
// R14: Continuous receive enables async receiver; in sync it repeats words.
// R15: Async nine-bit with address detect keeps only words with ninth bit set.
// R16: Framing error flags a bad stop bit, renewed with each loaded word.
// R17: Overrun error clears only when continuous receive or serial enable is cleared.
// R18: Ninth received bit is stored; no parity is computed.
// R19: Dedicated 8-bit free-running baud timer serves async and sync master.
// R20: Writing the baud value restarts the timer at once.
// R21: Bit rate is clock over 64, 16 or 4 times value plus one.
// R22: Each async bit is sampled three times and decided by majority.
// R23: Timer counts down, reloads at zero and emits one rate tick.
`include "asp_regs.svh"

module asp_core
  import asp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input asp_apb_req_type apbReq,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared pins
  input asp_pins_in_type pinIn,
  output asp_pins_out_type pinOut
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // R21 baud ticks per bit for the mode in use.
  function automatic logic [6:0] ticksPerBit(input logic syncMode, input logic high);
    if (syncMode) begin
      return `ASP_TICKS_SYNC;
    end else if (high) begin
      return `ASP_TICKS_HIGH;
    end else begin
      return `ASP_TICKS_LOW;
    end
  endfunction : ticksPerBit

  function automatic logic isMapped(input logic [7:0] addr);
    case (addr)
      `ASP_ADDR_TXCTL, `ASP_ADDR_RXCTL, `ASP_ADDR_BAUD, `ASP_ADDR_TXDATA,
      `ASP_ADDR_RXDATA, `ASP_ADDR_LATCH, `ASP_ADDR_DIR, `ASP_ADDR_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : isMapped

  asp_state_type s_q;
  asp_state_type s_d;

  logic serEn;
  logic syncMode;
  logic master;
  logic rxMode;
  logic tick;
  logic ck;
  logic ckRise;
  logic ckFall;
  logic dt;
  logic access;
  logic txStep;
  logic rxBit;
  logic rxDone;
  logic rxFerr;
  logic [3:0] rxLen;
  logic [6:0] perBit;
  logic [6:0] mid;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    serEn = s_q.rxCtl[`ASP_RXC_SEN];
    // R1 three modes.
    // R8 mode select.
    syncMode = s_q.txCtl[`ASP_TXC_SYNC];
    // R5 clock source only matters when synchronous.
    master = syncMode & s_q.txCtl[`ASP_TXC_CLKSRC];
    // R13 single receive ignored unless sync master; R14 continuous covers both.
    rxMode = syncMode & (s_q.rxCtl[`ASP_RXC_CONT] | (master & s_q.rxCtl[`ASP_RXC_SINGLE]));
    // R9 high-speed bit only reaches the async rate.
    perBit = ticksPerBit(syncMode, s_q.txCtl[`ASP_TXC_HIGH]);
    mid = perBit >> 1;
    // R12 receive width.
    rxLen = s_q.rxCtl[`ASP_RXC_NINE] ? 4'h9 : 4'h8;
    rxBit = 1'b0;
    rxDone = 1'b0;
    rxFerr = 1'b0;
    txStep = 1'b0;
    // Logic reads the second stage of each synchroniser, and the clock's third stage for edges.
    s_d.ckSync = {s_q.ckSync[1:0], pinIn.ckPin};
    s_d.dtSync = {s_q.dtSync[1:0], pinIn.dtPin};
    ck = s_q.ckSync[1];
    dt = s_q.dtSync[1];
    ckRise = ck & ~s_q.ckSync[2];
    ckFall = ~ck & s_q.ckSync[2];

    // R19 dedicated baud timer.
    // R23 down-count, reload at zero and tick.
    tick = 1'b0;
    if (s_q.baudCnt == 8'h00) begin
      s_d.baudCnt = s_q.baud;
      tick = 1'b1;
    end else begin
      s_d.baudCnt = s_q.baudCnt - 8'h01;
    end

    // APB: read data is captured in the setup cycle, effects land in the access cycle.
    access = apbReq.psel & apbReq.penable;
    if (apbReq.psel & ~apbReq.penable) begin
      s_d.rdata = 32'h0000_0000;
      case (apbReq.paddr)
        // R9 bit 3 reads zero; R10 empty status is the idle engine.
        `ASP_ADDR_TXCTL: s_d.rdata[7:0] = {s_q.txCtl[7:4], 1'b0, s_q.txCtl[2], ~s_q.txBusy,
                                           s_q.txCtl[0]};
        `ASP_ADDR_RXCTL: s_d.rdata[7:0] = {s_q.rxCtl[7:3], s_q.frameErr, s_q.overrun,
                                           s_q.rxNinth};
        `ASP_ADDR_BAUD: s_d.rdata[7:0] = s_q.baud;
        `ASP_ADDR_TXDATA: s_d.rdata[7:0] = s_q.txBuf;
        `ASP_ADDR_RXDATA: s_d.rdata[7:0] = s_q.rxData;
        `ASP_ADDR_LATCH: s_d.rdata[7:0] = s_q.portLatch;
        `ASP_ADDR_DIR: s_d.rdata[7:0] = s_q.portDir;
        `ASP_ADDR_STATUS: s_d.rdata[1:0] = {s_q.txBufFull, s_q.rxReady};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (access & apbReq.pwrite) begin
      case (apbReq.paddr)
        `ASP_ADDR_TXCTL: s_d.txCtl = apbReq.pwdata[7:0] & `ASP_TXC_WMASK;
        `ASP_ADDR_RXCTL: s_d.rxCtl = apbReq.pwdata[7:0] & `ASP_RXC_WMASK;
        `ASP_ADDR_BAUD: begin
          s_d.baud = apbReq.pwdata[7:0];
          // R20 restart the timer so the new rate applies at once.
          s_d.baudCnt = apbReq.pwdata[7:0];
          tick = 1'b0;
        end
        `ASP_ADDR_TXDATA: begin
          s_d.txBuf = apbReq.pwdata[7:0];
          s_d.txBufFull = 1'b1;
        end
        `ASP_ADDR_LATCH: s_d.portLatch = apbReq.pwdata[7:0];
        `ASP_ADDR_DIR: s_d.portDir = apbReq.pwdata[7:0];
        default: s_d.portDir = s_d.portDir;
      endcase
    end
    if (access & ~apbReq.pwrite & (apbReq.paddr == `ASP_ADDR_RXDATA)) begin
      s_d.rxReady = 1'b0;
    end

    // ----------------------------------------------------------------
    // Transmitter
    // ----------------------------------------------------------------
    if (!s_q.txBusy) begin
      // Except in sync slave mode a frame starts on a rate tick, so its first bit lasts a full bit time.
      // R7 transmit enable, overridden by receive enables in sync mode.
      if (s_q.txBufFull & s_q.txCtl[`ASP_TXC_EN] & ~rxMode & ~(syncMode & s_q.rxBusy) &
          (tick | (syncMode & ~master))) begin
        s_d.txBusy = 1'b1;
        s_d.txBufFull = access & apbReq.pwrite & (apbReq.paddr == `ASP_ADDR_TXDATA);
        s_d.txPhase = 7'h00;
        // R6 nine-bit frames carry the ninth bit from the control register.
        if (syncMode) begin
          s_d.txShift = {2'b11, s_q.txCtl[`ASP_TXC_NINTH], s_q.txBuf};
          s_d.txBits = s_q.txCtl[`ASP_TXC_NINE] ? 4'h9 : 4'h8;
        end else if (s_q.txCtl[`ASP_TXC_NINE]) begin
          s_d.txShift = {1'b1, s_q.txCtl[`ASP_TXC_NINTH], s_q.txBuf, 1'b0};
          s_d.txBits = 4'hB;
        end else begin
          s_d.txShift = {2'b11, s_q.txBuf, 1'b0};
          s_d.txBits = 4'hA;
        end
      end
    end else begin
      if (syncMode & ~master) begin
        txStep = ckFall;
      end else if (tick) begin
        s_d.txPhase = (s_q.txPhase == perBit - 7'h01) ? 7'h00 : s_q.txPhase + 7'h01;
        txStep = (s_q.txPhase == perBit - 7'h01);
      end
      if (txStep) begin
        s_d.txShift = {1'b1, s_q.txShift[10:1]};
        s_d.txBits = s_q.txBits - 4'h1;
        s_d.txBusy = (s_q.txBits != 4'h1);
      end
    end

    // ----------------------------------------------------------------
    // Receiver
    // ----------------------------------------------------------------
    if (!syncMode) begin
      // R14 continuous receive enables the async receiver; overrun stalls it.
      if (!s_q.rxBusy) begin
        if (tick & ~dt & s_q.rxCtl[`ASP_RXC_CONT] & ~s_q.overrun) begin
          s_d.rxBusy = 1'b1;
          s_d.rxPhase = 7'h00;
          s_d.rxIdx = 4'h0;
          s_d.rxWord = 9'h000;
        end
      end else if (tick) begin
        s_d.rxPhase = (s_q.rxPhase == perBit - 7'h01) ? 7'h00 : s_q.rxPhase + 7'h01;
        // R22 three samples around mid-bit, majority decides.
        if (s_q.rxPhase == mid - 7'h01) begin
          s_d.votes[0] = dt;
        end
        if (s_q.rxPhase == mid) begin
          s_d.votes[1] = dt;
        end
        if (s_q.rxPhase == mid + 7'h01) begin
          rxBit = (s_q.votes[0] & s_q.votes[1]) | (dt & (s_q.votes[0] | s_q.votes[1]));
          s_d.rxIdx = s_q.rxIdx + 4'h1;
          if (s_q.rxIdx == 4'h0) begin
            s_d.rxBusy = ~rxBit;
          end else if (s_q.rxIdx <= rxLen) begin
            s_d.rxWord[s_q.rxIdx - 4'h1] = rxBit;
          end else begin
            // R16 a low stop bit is a framing error.
            rxFerr = ~rxBit;
            rxDone = 1'b1;
            s_d.rxBusy = 1'b0;
          end
        end
      end
    end else if (rxMode) begin
      if (!s_q.rxBusy) begin
        s_d.rxBusy = 1'b1;
        s_d.rxPhase = 7'h00;
        s_d.rxIdx = 4'h0;
        s_d.rxWord = 9'h000;
      end else begin
        if (master & tick) begin
          s_d.rxPhase = (s_q.rxPhase == `ASP_SYNC_LAST) ? 7'h00 : s_q.rxPhase + 7'h01;
        end
        // Synchronised data lags the pin by two clocks, so sample late in the high half.
        if (master ? (tick & (s_q.rxPhase == `ASP_SYNC_LAST)) : ckRise) begin
          s_d.rxWord[s_q.rxIdx] = dt;
          s_d.rxIdx = s_q.rxIdx + 4'h1;
          if (s_q.rxIdx == rxLen - 4'h1) begin
            rxDone = 1'b1;
            s_d.rxBusy = 1'b0;
            s_d.rxWord = s_d.rxWord;
          end
        end
      end
    end else begin
      s_d.rxBusy = 1'b0;
    end

    if (rxDone) begin
      // R13 single receive self-clears after one word.
      if (master & ~s_q.rxCtl[`ASP_RXC_CONT]) begin
        s_d.rxCtl[`ASP_RXC_SINGLE] = 1'b0;
      end
      // R15 address detect drops async nine-bit words with ninth bit low.
      if (~(~syncMode & s_q.rxCtl[`ASP_RXC_NINE] & s_q.rxCtl[`ASP_RXC_ADDR] &
            ~s_d.rxWord[8])) begin
        if (s_q.rxReady & ~(s_d.rxReady == 1'b0 & s_q.rxReady)) begin
          s_d.overrun = 1'b1;
        end else begin
          s_d.rxData = s_d.rxWord[7:0];
          // R18 ninth bit stored as received, no parity check.
          s_d.rxNinth = s_d.rxWord[8];
          // R16 renewed with every word loaded into the buffer.
          s_d.frameErr = rxFerr;
          s_d.rxReady = 1'b1;
        end
      end
    end
    // R17 overrun falls when continuous receive is cleared.
    if (!s_d.rxCtl[`ASP_RXC_CONT]) begin
      s_d.overrun = 1'b0;
    end

    // R11 a cleared serial enable holds the channel in reset.
    if (!serEn) begin
      s_d.txBusy = 1'b0;
      s_d.txBufFull = 1'b0;
      s_d.rxBusy = 1'b0;
      s_d.rxReady = 1'b0;
      s_d.frameErr = 1'b0;
      s_d.overrun = 1'b0;
      s_d.baudCnt = s_d.baud;
    end

    // ----------------------------------------------------------------
    // Pins
    // ----------------------------------------------------------------
    if (serEn) begin
      // R3 the channel takes each pin as output when its operation needs it.
      if (!syncMode) begin
        s_d.pins.ckO = s_d.txBusy ? s_d.txShift[0] : 1'b1;
        s_d.pins.ckOe = 1'b1;
        s_d.pins.dtOe = 1'b0;
      end else begin
        s_d.pins.ckO = master & (s_d.txBusy ? s_d.txPhase[1] : s_d.rxBusy & s_d.rxPhase[1]);
        s_d.pins.ckOe = master;
        s_d.pins.dtOe = s_d.txBusy;
      end
      s_d.pins.dtO = s_d.txShift[0];
    end else begin
      s_d.pins.ckO = s_d.portLatch[`ASP_PIN_CK];
      s_d.pins.ckOe = ~s_d.portDir[`ASP_PIN_CK];
      s_d.pins.dtO = s_d.portLatch[`ASP_PIN_DT];
      s_d.pins.dtOe = ~s_d.portDir[`ASP_PIN_DT];
    end
    // R4 open drain: drive only the low level, release for high.
    if (s_d.portLatch[`ASP_LAT_OD]) begin
      s_d.pins.ckOe = s_d.pins.ckOe & ~s_d.pins.ckO;
      s_d.pins.ckO = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
      s_q.txCtl <= `ASP_CTL_RESET;
      s_q.rxCtl <= `ASP_CTL_RESET;
      s_q.portDir <= `ASP_DIR_RESET;
      s_q.txShift <= '1;
      s_q.ckSync <= '1;
      s_q.dtSync <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The slave never waits, so a transfer is two cycles; unmapped offsets error out.
  assign pready = 1'b1;
  assign pslverr = access & ~isMapped(apbReq.paddr);
  assign prdata = s_q.rdata;
  assign pinOut = s_q.pins;

endmodule : asp_core

// *** sim/asp_chk.sv ***
// Port checker of the serial channel, bound to the core.
`include "asp_regs.svh"
module asp_chk
  import asp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input asp_apb_req_type apbReq,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Shared pins
  input asp_pins_in_type pinIn,
  input asp_pins_out_type pinOut
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shadow of dir, latch, receive and transmit control; pins lag it, so it must be steady.
  logic [31:0] sh_q;
  logic [31:0] shP_q;
  logic acc;
  logic stb;
  logic sen;
  logic syn;
  logic mst;
  logic od;
  assign acc = apbReq.psel && apbReq.penable;
  assign stb = (sh_q == shP_q);
  assign sen = sh_q[8 + `ASP_RXC_SEN];
  assign syn = sh_q[`ASP_TXC_SYNC];
  assign mst = sh_q[`ASP_TXC_CLKSRC];
  assign od = sh_q[16 + `ASP_LAT_OD];
  always_ff @(posedge clk) begin
    shP_q <= sh_q;
    if (srst) begin
      sh_q <= {`ASP_DIR_RESET, 8'h00, `ASP_CTL_RESET, `ASP_CTL_RESET};
    end else if (acc && apbReq.pwrite) begin
      case (apbReq.paddr)
        `ASP_ADDR_TXCTL: sh_q[7:0] <= apbReq.pwdata[7:0];
        `ASP_ADDR_RXCTL: sh_q[15:8] <= apbReq.pwdata[7:0];
        `ASP_ADDR_LATCH: sh_q[23:16] <= apbReq.pwdata[7:0];
        `ASP_ADDR_DIR: sh_q[31:24] <= apbReq.pwdata[7:0];
        default: ;
      endcase
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_steady;
    stb [*2];
  endsequence
  property p_bit3;
    acc && !apbReq.pwrite && apbReq.paddr == `ASP_ADDR_TXCTL |-> prdata[3] == 1'b0;
  endproperty
  a_bit3: assert property (p_bit3) else $error("bit 3 set");
  property p_upper;
    prdata[31:8] == 24'h000000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper data set");
  property p_od;
    s_steady ##0 (sen && od) |-> !(pinOut.ckOe && pinOut.ckO);
  endproperty
  a_od: assert property (p_od) else $error("driven high");
  property p_gpio;
    s_steady ##0 (!sen && !od) |-> pinOut.ckOe == !sh_q[24 + `ASP_PIN_CK]
      && pinOut.dtOe == !sh_q[24 + `ASP_PIN_DT]
      && (!pinOut.ckOe || pinOut.ckO == sh_q[16 + `ASP_PIN_CK]);
  endproperty
  a_gpio: assert property (p_gpio) else $error("port pins wrong");
  property p_rxin;
    s_steady ##0 (sen && !syn) |-> !pinOut.dtOe;
  endproperty
  a_rxin: assert property (p_rxin) else $error("data pin driven");
  property p_slave;
    s_steady ##0 (sen && syn && !mst) |-> !pinOut.ckOe;
  endproperty
  a_slave: assert property (p_slave) else $error("slave drives clock");
  property p_master;
    s_steady ##0 (sen && syn && mst && !od) |-> pinOut.ckOe;
  endproperty
  a_master: assert property (p_master) else $error("master clock idle");
  property p_rst;
    $fell(srst) |-> prdata == 32'h0 && !pinOut.ckOe && !pinOut.dtOe;
  endproperty
  a_rst: assert property (p_rst) else $error("not quiet after reset");
endmodule : asp_chk
bind asp_core asp_chk chk_u (
  .clk(clk), .srst(srst), .apbReq(apbReq), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut)
);

// *** sim/asp_partner.sv ***
// Behavioural serial device on the far side of the channel's pins.
module asp_partner
  import asp_pkg::*;
(
  // Clock
  input wire logic clk,
  // Transmit/clock line level
  input wire logic ckLine,
  // Receive/data pin drive
  output logic dtO,
  output logic dtOe,
  // Slave clock drive and data line level
  output logic ckDrv,
  output logic ckDrvOe,
  input wire logic dtLine
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    dtO = 1'b1;
    dtOe = 1'b0;
    ckDrv = 1'b0;
    ckDrvOe = 1'b0;
  end
  // external clock for slave mode, data read at each rising edge.
  task automatic sync_clock(input int n, output logic [8:0] d);
    d = 9'h000;
    ckDrvOe <= 1'b1;
    ckDrv <= 1'b0;
    for (int i = 0; i < n; i++) begin
      repeat (6) @(posedge clk);
      ckDrv <= 1'b1;
      d[i] = dtLine;
      repeat (6) @(posedge clk);
      ckDrv <= 1'b0;
    end
    repeat (6) @(posedge clk);
    ckDrvOe <= 1'b0;
  endtask : sync_clock
  // LSB first, optional ninth bit; a glitch tests the vote.
  task automatic send(input logic [8:0] d, input int n, input int bc, input logic stp,
                      input logic g);
    dtOe <= 1'b1;
    dtO <= 1'b0;
    repeat (bc) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      dtO <= d[i];
      repeat (bc / 2) @(posedge clk);
      dtO <= d[i] ^ g;
      @(posedge clk);
      dtO <= d[i];
      repeat (bc - bc / 2 - 1) @(posedge clk);
    end
    dtO <= stp;
    repeat (bc) @(posedge clk);
    dtOe <= 1'b0;
    repeat (bc) @(posedge clk);
  endtask : send
  // bit time measured on the start bit.
  task automatic recv(input int n, output logic [9:0] d, output int p);
    p = 0;
    d = 10'h000;
    while (ckLine !== 1'b0) @(posedge clk);
    while (ckLine === 1'b0) begin
      @(posedge clk);
      p++;
    end
    repeat (p / 2) @(posedge clk);
    for (int i = 0; i <= n; i++) begin
      d[i] = ckLine;
      repeat (p) @(posedge clk);
    end
  endtask : recv
  // slave data changes after falling clock, read at rising.
  task automatic sync_send(input logic [7:0] d);
    dtOe <= 1'b1;
    dtO <= d[0];
    for (int i = 1; i < 8; i++) begin
      @(posedge ckLine);
      @(negedge ckLine);
      dtO <= d[i];
    end
    @(posedge ckLine);
    @(negedge ckLine);
    dtOe <= 1'b0;
  endtask : sync_send
endmodule : asp_partner

// *** sim/tb_top.sv ***
// Self-checking bench of the serial channel: register access and serial frames.
`include "asp_regs.svh"
module tb_top
  import asp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk;
  logic srst;
  asp_apb_req_type req;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  asp_pins_in_type pinIn;
  asp_pins_out_type pinOut;
  logic ckLine;
  logic dtLine;
  logic pO;
  logic pOe;
  logic pC;
  logic pCOe;
  logic [8:0] sd;
  int mismatches = 0;
  int cmp_count = 0;
  logic [9:0] fr;
  int per;
  logic [31:0] rd;
  logic er;
  // Both lines have pull-ups, which also give the open-drain high level.
  assign ckLine = pinOut.ckOe ? pinOut.ckO : (pCOe ? pC : 1'b1);
  assign dtLine = pinOut.dtOe ? pinOut.dtO : (pOe ? pO : 1'b1);
  assign pinIn = {ckLine, dtLine};
  asp_core dut_u (
    .clk(clk), .srst(srst), .apbReq(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut)
  );
  asp_partner far_u (
    .clk(clk), .ckLine(ckLine), .dtO(pO), .dtOe(pOe), .ckDrv(pC), .ckDrvOe(pCOe),
    .dtLine(dtLine)
  );
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic e);
    req.psel <= 1'b1;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clk);
    req.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    d = prdata;
    e = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, rd, er);
  endtask : wr
  task automatic chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] d;
    logic x;
    apb(1'b0, a, 32'h0, d, x);
    check($sformatf("reg %h", a), {24'h0, e & m}, d & {24'h0, m});
  endtask : chk
  task automatic poll();
    logic [31:0] d;
    logic x;
    int n;
    n = 0;
    d = 32'h0;
    while (d[0] !== 1'b1 && n < 400) begin
      apb(1'b0, `ASP_ADDR_STATUS, 32'h0, d, x);
      n++;
    end
    check("rx ready", 32'h1, {31'h0, d[0]});
  endtask : poll
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  initial begin
    req = '0;
    srst = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(`ASP_ADDR_TXCTL, 8'hFF, 8'h02);
    chk(`ASP_ADDR_RXCTL, 8'hFE, 8'h00);
    wr(`ASP_ADDR_TXCTL, 8'hFF);
    chk(`ASP_ADDR_TXCTL, 8'hFF, 8'hF7);
    apb(1'b0, 8'h20, 32'h0, rd, er);
    check("unmapped", 32'h80000000, {er, rd[30:0]});
    wr(`ASP_ADDR_DIR, 8'hF9);
    repeat (4) @(posedge clk);
    check("port pins", 32'h0, {30'h0, ckLine, dtLine});
    wr(`ASP_ADDR_DIR, 8'hFF);
    wr(`ASP_ADDR_BAUD, 8'h01);
    wr(`ASP_ADDR_TXCTL, 8'h20);
    wr(`ASP_ADDR_RXCTL, 8'h80);
    fork
      far_u.recv(8, fr, per);
      begin
        wr(`ASP_ADDR_TXDATA, 8'hA5);
        chk(`ASP_ADDR_TXCTL, 8'h02, 8'h00);
      end
    join
    check("frame", 32'h1A5, {22'h0, fr});
    check("bit clocks", 32'h80, per);
    wr(`ASP_ADDR_LATCH, 8'h80);
    wr(`ASP_ADDR_BAUD, 8'h02);
    wr(`ASP_ADDR_TXCTL, 8'h65);
    fork
      far_u.recv(9, fr, per);
      wr(`ASP_ADDR_TXDATA, 8'h3D);
    join
    check("frame9", 32'h33D, {22'h0, fr});
    check("bit clocks", 32'h30, per);
    wr(`ASP_ADDR_RXCTL, 8'h90);
    far_u.send(9'h05A, 8, 48, 1'b1, 1'b1);
    poll();
    chk(`ASP_ADDR_RXDATA, 8'hFF, 8'h5A);
    chk(`ASP_ADDR_RXCTL, 8'h06, 8'h00);
    far_u.send(9'h0C3, 8, 48, 1'b0, 1'b0);
    poll();
    chk(`ASP_ADDR_RXCTL, 8'h04, 8'h04);
    chk(`ASP_ADDR_RXDATA, 8'hFF, 8'hC3);
    far_u.send(9'h011, 8, 48, 1'b1, 1'b0);
    far_u.send(9'h022, 8, 48, 1'b1, 1'b0);
    chk(`ASP_ADDR_RXCTL, 8'h06, 8'h02);
    wr(`ASP_ADDR_RXCTL, 8'h80);
    chk(`ASP_ADDR_RXCTL, 8'h02, 8'h00);
    chk(`ASP_ADDR_RXDATA, 8'hFF, 8'h11);
    wr(`ASP_ADDR_RXCTL, 8'hD8);
    far_u.send(9'h011, 9, 48, 1'b1, 1'b0);
    chk(`ASP_ADDR_STATUS, 8'h01, 8'h00);
    far_u.send(9'h177, 9, 48, 1'b1, 1'b0);
    poll();
    chk(`ASP_ADDR_RXCTL, 8'h01, 8'h01);
    chk(`ASP_ADDR_RXDATA, 8'hFF, 8'h77);
    wr(`ASP_ADDR_LATCH, 8'h00);
    wr(`ASP_ADDR_BAUD, 8'h00);
    wr(`ASP_ADDR_RXCTL, 8'h80);
    wr(`ASP_ADDR_TXCTL, 8'h90);
    fork
      far_u.sync_send(8'h96);
      wr(`ASP_ADDR_RXCTL, 8'hA0);
    join
    poll();
    chk(`ASP_ADDR_RXDATA, 8'hFF, 8'h96);
    chk(`ASP_ADDR_RXCTL, 8'h20, 8'h00);
    wr(`ASP_ADDR_TXCTL, 8'h30);
    fork
      far_u.sync_clock(8, sd);
      wr(`ASP_ADDR_TXDATA, 8'h5C);
    join
    check("slave tx", 32'h5C, {24'h0, sd[7:0]});
    wr(`ASP_ADDR_TXCTL, 8'h10);
    repeat (4) @(posedge clk);
    end_of_test();
  end
endmodule : tb_top
